// ==== logic/recr_top.sv ====
// control register bank of the io buck, peripheral buck and linear regulator 1
`timescale 1ns/1ps
`include "recr_defs.svh"
module recr_top
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output recr_pkg::recr_resp_type    s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output recr_pkg::recr_resp_type    s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  control_pin_one,
    input  wire logic                  control_pin_two,
    input  wire logic                  control_pin_thirteen,
    input  wire logic                  seq_run,
    input  wire logic                  seq_to_active,
    output logic                       io_buck_enable,
    output logic                       io_buck_preset_b,
    output logic                       periph_buck_enable,
    output logic                       periph_buck_preset_b,
    output logic                       periph_load_switch_closed,
    output logic                       linear1_enable,
    output logic                       linear1_preset_b,
    output logic                       linear1_pull_down
);
    import recr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end
        else
        begin
            pin_meta <= {control_pin_thirteen, control_pin_two, control_pin_one};
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] io_buck_control;
    logic [7:0] peripheral_buck_control;
    logic [7:0] linear_reg1_control;

    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // one-hot word decode: io, peripheral, linear1, rail state, pin status
    function automatic logic [4:0] decode_addr(input logic [11:0] a);
        logic [11:0] w;
        logic [4:0]  hit;
        w      = {a[11:2], 2'h0};
        hit[0] = (w == {2'h0, `RECR_IO_BUCK_INDEX, 2'h0});
        hit[1] = (w == {2'h0, `RECR_PERIPH_BUCK_INDEX, 2'h0});
        hit[2] = (w == {2'h0, `RECR_LINEAR1_INDEX, 2'h0});
        hit[3] = (w == `RECR_RAIL_STATE_ADDR);
        hit[4] = (w == `RECR_PIN_STATUS_ADDR);
        return hit;
    endfunction

    wire       aw_take  = s_axi_awvalid & s_axi_awready;
    wire       w_take   = s_axi_wvalid & s_axi_wready;
    wire       wr_fire  = aw_held & w_held & ~s_axi_bvalid;
    wire       wr_lane0 = w_strb[0];
    wire [4:0] wr_dec   = decode_addr(aw_addr);
    wire       wr_io    = wr_fire & wr_lane0 & wr_dec[0];
    wire       wr_pb    = wr_fire & wr_lane0 & wr_dec[1];
    wire       wr_l1    = wr_fire & wr_lane0 & wr_dec[2];
    wire       wr_hit   = |wr_dec;

    // write address and data are taken in either order, response after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RECR_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid;
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RECR_RESP_OKAY : RECR_RESP_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // only documented bits are stored; reserved bits read zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            io_buck_control         <= `RECR_REG_RESET;
            peripheral_buck_control <= `RECR_REG_RESET;
            linear_reg1_control     <= `RECR_REG_RESET;
        end
        else
        begin
            if (wr_io)
            begin
                io_buck_control <= w_data[7:0] & `RECR_IO_MASK;
            end
            if (wr_pb)
            begin
                peripheral_buck_control <= w_data[7:0] & `RECR_PERIPH_MASK;
            end
            if (wr_l1)
            begin
                linear_reg1_control <= w_data[7:0] & `RECR_LINEAR1_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rails
    logic io_on;
    logic io_pb;
    logic pb_on;
    logic pb_pb;
    logic l1_on;
    logic l1_pb;
    logic sw_seq;

    recr_rail_gate u_io
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .pins          (pin_sync),
        .seq_run       (seq_run),
        .seq_to_active (seq_to_active),
        .on_bit        (io_buck_control[`RECR_ON_BIT]),
        .seq_target    (io_buck_control[`RECR_SEQ_BIT]),
        .gate_sel      (recr_pin_sel_type'(io_buck_control[`RECR_GATE_LSB +: 2])),
        .preset_sel    (recr_pin_sel_type'(io_buck_control[`RECR_PRESET_LSB +: 2])),
        .rail_on       (io_on),
        .preset_b      (io_pb)
    );

    recr_rail_gate u_pb
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .pins          (pin_sync),
        .seq_run       (seq_run),
        .seq_to_active (seq_to_active),
        .on_bit        (peripheral_buck_control[`RECR_ON_BIT]),
        .seq_target    (peripheral_buck_control[`RECR_SEQ_BIT]),
        .gate_sel      (recr_pin_sel_type'(peripheral_buck_control[`RECR_GATE_LSB +: 2])),
        .preset_sel    (recr_pin_sel_type'(peripheral_buck_control[`RECR_PRESET_LSB +: 2])),
        .rail_on       (pb_on),
        .preset_b      (pb_pb)
    );

    recr_rail_gate u_l1
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .pins          (pin_sync),
        .seq_run       (seq_run),
        .seq_to_active (seq_to_active),
        .on_bit        (linear_reg1_control[`RECR_ON_BIT]),
        .seq_target    (linear_reg1_control[`RECR_L1_SEQ_BIT]),
        .gate_sel      (recr_pin_sel_type'(linear_reg1_control[`RECR_GATE_LSB +: 2])),
        .preset_sel    (recr_pin_sel_type'(linear_reg1_control[`RECR_PRESET_LSB +: 2])),
        .rail_on       (l1_on),
        .preset_b      (l1_pb)
    );

    // sequencer copy of the load switch target
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_seq <= 1'b1;
        end
        else if (seq_run)
        begin
            sw_seq <= seq_to_active | peripheral_buck_control[`RECR_SW_SEQ_BIT];
        end
    end

    wire next_switch = peripheral_buck_control[`RECR_SW_BIT] & sw_seq;
    wire next_pull   = ~linear_reg1_control[`RECR_L1_DISCH_BIT] & ~l1_on;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            io_buck_enable            <= 1'b0;
            io_buck_preset_b          <= 1'b0;
            periph_buck_enable        <= 1'b0;
            periph_buck_preset_b      <= 1'b0;
            periph_load_switch_closed <= 1'b0;
            linear1_enable            <= 1'b0;
            linear1_preset_b          <= 1'b0;
            linear1_pull_down         <= 1'b0;
        end
        else
        begin
            io_buck_enable            <= io_on;
            io_buck_preset_b          <= io_pb;
            periph_buck_enable        <= pb_on;
            periph_buck_preset_b      <= pb_pb;
            periph_load_switch_closed <= next_switch;
            linear1_enable            <= l1_on;
            linear1_preset_b          <= l1_pb;
            linear1_pull_down         <= next_pull;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    wire [4:0] rd_dec     = decode_addr(s_axi_araddr);
    wire       rd_hit     = |rd_dec;
    wire [7:0] rail_state = {io_buck_enable, periph_buck_enable, periph_load_switch_closed,
                             linear1_enable, linear1_pull_down, linear1_preset_b,
                             periph_buck_preset_b, io_buck_preset_b};
    wire [7:0] rd_byte    = rd_dec[0] ? io_buck_control :
                            rd_dec[1] ? peripheral_buck_control :
                            rd_dec[2] ? linear_reg1_control :
                            rd_dec[3] ? rail_state :
                            rd_dec[4] ? {5'h00, pin_sync} : 8'h00;

    wire ar_take = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RECR_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? RECR_RESP_OKAY : RECR_RESP_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== logic/recr_defs.svh ====
// register offsets, field positions and reset values of the rail control bank
`ifndef RECR_DEFS_SVH
`define RECR_DEFS_SVH
`define RECR_IO_BUCK_INDEX      8'h24
`define RECR_PERIPH_BUCK_INDEX  8'h25
`define RECR_LINEAR1_INDEX      8'h26
`define RECR_RAIL_STATE_ADDR    12'h0A0
`define RECR_PIN_STATUS_ADDR    12'h0A4
`define RECR_REG_RESET          8'h00
`define RECR_ON_BIT             0
`define RECR_GATE_LSB           1
`define RECR_SEQ_BIT            3
`define RECR_SW_BIT             4
`define RECR_PRESET_LSB         5
`define RECR_SW_SEQ_BIT         7
`define RECR_L1_SEQ_BIT         7
`define RECR_L1_DISCH_BIT       3
`define RECR_IO_MASK            8'h6F
`define RECR_PERIPH_MASK        8'hFF
`define RECR_LINEAR1_MASK       8'hEF
`endif

// ==== logic/recr_pkg.sv ====
// types of the rail control bank
package recr_pkg;
    typedef enum logic [1:0]
    {
        RECR_SEL_SEQ   = 2'b00,
        RECR_SEL_PIN1  = 2'b01,
        RECR_SEL_PIN2  = 2'b10,
        RECR_SEL_PIN13 = 2'b11
    } recr_pin_sel_type;
    typedef enum logic [1:0]
    {
        RECR_RESP_OKAY   = 2'b00,
        RECR_RESP_SLVERR = 2'b10
    } recr_resp_type;
endpackage

// ==== logic/recr_rail_gate.sv ====
// one rail: pin gating of enable and preset selection
`timescale 1ns/1ps
module recr_rail_gate
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [2:0]                 pins,
    input  wire logic                       seq_run,
    input  wire logic                       seq_to_active,
    input  wire logic                       on_bit,
    input  wire logic                       seq_target,
    input  wire recr_pkg::recr_pin_sel_type gate_sel,
    input  wire recr_pkg::recr_pin_sel_type preset_sel,
    output logic                            rail_on,
    output logic                            preset_b
);
    import recr_pkg::*;

    // picks the pin a select field names
    function automatic logic pick(input recr_pin_sel_type s, input logic [2:0] p);
        logic r;
        r = 1'b0;
        unique case (s)
            RECR_SEL_SEQ:   r = 1'b0;
            RECR_SEL_PIN1:  r = p[0];
            RECR_SEL_PIN2:  r = p[1];
            RECR_SEL_PIN13: r = p[2];
        endcase
        return r;
    endfunction

    logic seq_on;
    logic seq_preset_b;
    wire  gate_pin       = pick(gate_sel, pins);
    wire  preset_pin     = pick(preset_sel, pins);
    wire  gate_by_seq    = (gate_sel == RECR_SEL_SEQ);
    wire  preset_by_seq  = (preset_sel == RECR_SEL_SEQ);
    wire  next_rail_on   = on_bit & (gate_by_seq ? seq_on : gate_pin);
    wire  next_preset_b  = preset_by_seq ? seq_preset_b : ~preset_pin;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seq_on       <= 1'b1;
            seq_preset_b <= 1'b0;
            rail_on      <= 1'b0;
            preset_b     <= 1'b0;
        end
        else
        begin
            if (seq_run)
            begin
                seq_on       <= seq_to_active | seq_target;
                seq_preset_b <= ~seq_to_active;
            end
            rail_on  <= next_rail_on;
            preset_b <= next_preset_b;
        end
    end
endmodule

// ==== verif/recr_props.sv ====
// port assertions of the rail control bank
`timescale 1ns/1ps
module recr_props
(
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire recr_pkg::recr_resp_type s_axi_bresp,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic [11:0]             s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire recr_pkg::recr_resp_type s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire logic                    io_buck_enable,
    input wire logic                    io_buck_preset_b,
    input wire logic                    periph_buck_enable,
    input wire logic                    periph_buck_preset_b,
    input wire logic                    periph_load_switch_closed,
    input wire logic                    linear1_enable,
    input wire logic                    linear1_preset_b,
    input wire logic                    linear1_pull_down
);
    import recr_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire [7:0] st = {io_buck_enable, periph_buck_enable, periph_load_switch_closed, linear1_enable,
                     linear1_pull_down, linear1_preset_b, periph_buck_preset_b, io_buck_preset_b};
    wire        ar_go   = s_axi_arvalid && s_axi_arready;
    wire [11:0] ar_word = {s_axi_araddr[11:2], 2'h0};
    wire        ar_ok   = ar_word inside {12'h090, 12'h094, 12'h098, 12'h0A0, 12'h0A4};
    ////////////////////////////////////////
    chk_rd_answer: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write not answered two cycles after the take");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped early");
    chk_unmapped_err: assert property (ar_go && !ar_ok |=> s_axi_rresp == RECR_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_io_reserved: assert property (ar_go && ar_word == 12'h090 |=> !s_axi_rdata[7] && !s_axi_rdata[4])
        else $error("io buck reserved bits stored");
    chk_pd_off: assert property (linear1_pull_down |-> !linear1_enable)
        else $error("pull-down engaged while enabled");
    chk_state_view: assert property (ar_go && ar_word == 12'h0A0 && $stable(st) ##1 $stable(st)
        |-> s_axi_rdata[7:0] == $past(st))
        else $error("rail state read differs from ports");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (ar_go && !ar_ok);
    cover property ($fell(linear1_pull_down));
endmodule

// ==== verif/recr_pins_model.sv ====
// far side: control pins and sequencer strobe
`timescale 1ns/1ps
module recr_pins_model
(
    input  wire logic       aclk,
    input  wire logic [2:0] want,
    input  wire logic       go,
    input  wire logic       dir,
    output logic            control_pin_one,
    output logic            control_pin_two,
    output logic            control_pin_thirteen,
    output logic            seq_run,
    output logic            seq_to_active
);
    initial {control_pin_thirteen, control_pin_two, control_pin_one, seq_run, seq_to_active} = 5'h00;
    // pins follow the bench one edge late; the design synchronises them
    always @(posedge aclk)
    begin
        {control_pin_thirteen, control_pin_two, control_pin_one} <= want;
        seq_run       <= go;
        seq_to_active <= dir;
    end
endmodule

// ==== verif/regulator_enable_control_regs_test.sv ====
// self-checking bench of the rail control bank
`timescale 1ns/1ps
`include "recr_defs.svh"
module regulator_enable_control_regs_test;
    import recr_pkg::*;
    logic          aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic          s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic          s_axi_arready, s_axi_rvalid, control_pin_one, control_pin_two, control_pin_thirteen;
    logic          seq_run, seq_to_active, io_buck_enable, io_buck_preset_b, periph_buck_enable;
    logic          periph_buck_preset_b, periph_load_switch_closed, linear1_enable, linear1_preset_b;
    logic          linear1_pull_down, go = 0, dir = 0, pst = 0, slow = 0;
    logic [11:0]   s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]   s_axi_wdata = 0, s_axi_rdata, v, seed = 32'hEA928A5C;
    logic [3:0]    s_axi_wstrb = 0, sq = 4'hF;
    logic [2:0]    want = 0;
    logic [7:0]    r [3] = '{8'h00, 8'h00, 8'h00};
    logic [11:0]   ad [3] = '{12'h090, 12'h094, 12'h098};
    logic [7:0]    mk [3] = '{`RECR_IO_MASK, `RECR_PERIPH_MASK, `RECR_LINEAR1_MASK};
    recr_resp_type s_axi_bresp, s_axi_rresp, bq [$];
    logic [33:0]   rq [$];
    int            err_total = 0, cmp_count = 0, i;
    recr_top recr_top_inst (.*);
    recr_pins_model recr_pins_model_inst (.*);
    initial forever #2.5 aclk = ~aclk;
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic pin(logic [1:0] s);
        return want[s - 2'h1];
    endfunction
    function automatic logic en(logic [7:0] x, logic q);
        return x[0] & (x[2:1] == 2'b00 ? q : pin(x[2:1]));
    endfunction
    function automatic logic pb(logic [7:0] x);
        return x[6:5] == 2'b00 ? pst : !pin(x[6:5]);
    endfunction
    function automatic logic [7:0] st();
        logic l1;
        l1 = en(r[2], sq[3]);
        return {en(r[0], sq[0]), en(r[1], sq[1]), r[1][4] & sq[2], l1, !r[2][3] & !l1, pb(r[2]), pb(r[1]), pb(r[0])};
    endfunction
    task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input recr_resp_type e);
        logic adn, wdn;
        bq.push_back(e);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid  <= 1;
        s_axi_bready  <= !slow;
        adn = 0;
        wdn = 0;
        while (!(adn && wdn))
        begin
            @(posedge aclk);
            adn = adn | s_axi_awready;
            wdn = wdn | s_axi_wready;
            s_axi_awvalid <= !adn;
            s_axi_wvalid  <= !wdn;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        if (slow)
        begin
            s_axi_bready <= 1;
            @(posedge aclk);
        end
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1;
        s_axi_rready  <= !slow;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        if (slow)
        begin
            s_axi_rready <= 1;
            @(posedge aclk);
        end
        s_axi_rready <= 0;
    endtask
    task automatic seq(input logic d);
        @(posedge aclk);
        go  <= 1;
        dir <= d;
        @(posedge aclk);
        go  <= 0;
        sq  = d ? 4'hF : {r[2][7], r[1][7], r[1][3], r[0][3]};
        pst = !d;
    endtask
    ////////////////////////////////////////
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            cmp("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (6) @(posedge aclk);
        for (i = 0; i < 3; i++)
            rd(ad[i], 34'h0);
        rd(`RECR_RAIL_STATE_ADDR, {RECR_RESP_OKAY, 24'h0, st()});
        rd(12'h0B0, {RECR_RESP_SLVERR, 32'h0});
        wr(12'h0B0, 32'h1, 4'h1, RECR_RESP_SLVERR);
        wr(`RECR_RAIL_STATE_ADDR, 32'hFF, 4'h1, RECR_RESP_OKAY);
        for (int k = 0; k < 90; k++)
        begin
            v = rnd();
            i = v[9:8] % 3;
            slow = v[14];
            if (v[11:10] < 2)
            begin
                wr(ad[i], v, v[15:12], RECR_RESP_OKAY);
                if (v[12])
                    r[i] = v[7:0] & mk[i];
            end
            else if (v[11:10] == 2)
                want <= v[2:0];
            else
                seq(v[13]);
            repeat (6) @(posedge aclk);
            rd(ad[i], {RECR_RESP_OKAY, 24'h0, r[i]});
            rd(`RECR_PIN_STATUS_ADDR, {RECR_RESP_OKAY, 29'h0, want});
            rd(`RECR_RAIL_STATE_ADDR, {RECR_RESP_OKAY, 24'h0, st()});
        end
        final_report();
    end
    initial
    begin
        repeat (40000) @(posedge aclk);
        err_total++;
        final_report();
    end
endmodule
bind recr_top recr_props recr_props_inst (.*);
